// file: src/frame_event_if.sv
`timescale 1ns/10ps
// carries a finished frame from the serial-clock domain to the core
interface frame_event_if
    import sector_guard_pkg::*;
;
    logic toggle;
    job_t job;
    logic [63:0] data;
    logic [7:0] count;
    logic [23:0] addr;
    modport link (output toggle, output job, output data, output count,
        output addr);
    modport core (input toggle, input job, input data, input count,
        input addr);
endinterface : frame_event_if

// file: src/sector_guard.sv
`timescale 1ns/10ps
module sector_guard
    import sector_guard_pkg::*;
#(
    parameter int program_cycles = self_timed_program_cycles,
    parameter int buffer_depth = 264
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic protect_enable,
    output logic so,
    output logic so_oe,
    output logic busy,
    output logic [7:0] sector_locked,
    output logic [7:0] sector_write_allowed
);
    // ------------------------------------------------------------
    // nonvolatile state
    // ------------------------------------------------------------
    logic [63:0] sector_protect_select;
    logic [63:0] sector_permanent_lock;
    logic [7:0] buffer_one [buffer_depth];
    logic link_so;
    logic link_rd;
    logic [2:0] ev_sync;
    logic [63:0] prot_data;
    logic [7:0] prot_count;
    logic [23:0] lock_addr;
    logic [31:0] busy_cnt;
    logic [2:0] fill_idx;
    logic filling;
    job_t job;
    job_t next_job;

    frame_event_if ev ();

    sector_guard_link link (
        .sck(sck),
        .reset_n(reset_n),
        .cs_n(cs_n),
        .si(si),
        .protect_q(sector_protect_select),
        .lock_q(sector_permanent_lock),
        .so(link_so),
        .rd_active(link_rd),
        .ev(ev)
    );

    // ------------------------------------------------------------
    // output pin: driven while a read frame is open and until the first clk edge after cs_n rises
    // ------------------------------------------------------------
    // so is launched in the sck domain and passes through one clk flop here;
    // the enable is registered too, so it drops on the first clk edge after cs_n rises
    always_ff @(posedge clk) begin
        so <= link_so;
        so_oe <= link_rd && !cs_n;
    end

    // ------------------------------------------------------------
    // event crossing: toggle through two flops, then edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n)
            ev_sync <= 3'h0;
        else
            ev_sync <= {ev_sync[1:0], ev.toggle};
    end

    // payload is stable long before the toggle settles here
    always_comb begin
        next_job = job_none;
        if (ev_sync[2] != ev_sync[1] && job == job_none)
            next_job = ev.job;
    end

    // ------------------------------------------------------------
    // self-timed cycle; busy stands until the count expires
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            job <= job_none;
            busy_cnt <= 32'h0;
            busy <= 1'b0;
        end else if (job == job_none) begin
            if (next_job != job_none) begin
                job <= next_job;
                busy_cnt <= 32'(program_cycles);
                busy <= 1'b1;
            end
        end else if (busy_cnt == 32'h1) begin
            job <= job_none;
            busy <= 1'b0;
        end else begin
            busy_cnt <= busy_cnt - 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (next_job != job_none) begin
            prot_data <= ev.data;
            prot_count <= ev.count;
            lock_addr <= ev.addr;
        end
    end

    // ------------------------------------------------------------
    // buffer one is used as scratch for the program data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            filling <= 1'b0;
            fill_idx <= 3'h0;
        end else if (next_job == job_program) begin
            filling <= 1'b1;
            fill_idx <= 3'h0;
        end else if (filling) begin
            fill_idx <= fill_idx + 3'h1;
            if (fill_idx == 3'h7)
                filling <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (filling)
            buffer_one[fill_idx] <= prot_data[8*(7 - fill_idx) +: 8];
    end

    // ------------------------------------------------------------
    // commit at end of cycle; bytes not received keep old value,
    // which is one legal outcome of undefined
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sector_protect_select <= protect_reset;
        end else if (job == job_program && busy_cnt == 32'h1) begin
            for (int i = 0; i < sector_count; i++) begin
                if (prot_count >= 8'(sector_count)
                    || i < int'(prot_count))
                    sector_protect_select[8*(7 - i) +: 8] <=
                        prot_data[8*(7 - i) +: 8];
            end
        end
    end

    // lock bits only ever set; reset clears simulation state only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sector_permanent_lock <= 64'h0;
        end else if (job == job_lockdown && busy_cnt == 32'h1) begin
            if (lock_addr[sector_lsb +: 3] == 3'h0) begin
                if (lock_addr[sector_lsb-1:page_lsb] <
                    8'(part0a_page_limit))
                    sector_permanent_lock[63:56] <=
                        sector_permanent_lock[63:56] | part0a_mask;
                else
                    sector_permanent_lock[63:56] <=
                        sector_permanent_lock[63:56] | part0b_mask;
            end else begin
                sector_permanent_lock[8*(7 - lock_addr[sector_lsb +: 3]) +: 8]
                    <= byte_set;
            end
        end
    end

    // ------------------------------------------------------------
    // status seen by the array program/erase path
    // ------------------------------------------------------------
    generate
        for (genvar s = 0; s < sector_count; s++) begin : g_sec
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    sector_locked[s] <= 1'b0;
                    sector_write_allowed[s] <= 1'b1;
                end else begin
                    sector_locked[s] <=
                        sector_permanent_lock[8*(7-s) +: 8] != byte_clear;
                    sector_write_allowed[s] <=
                        sector_permanent_lock[8*(7-s) +: 8] == byte_clear
                        && !(protect_enable &&
                        sector_protect_select[8*(7-s) +: 8] != byte_clear);
                end
            end
        end
    endgenerate
endmodule : sector_guard

// file: src/sector_guard_link.sv
`timescale 1ns/10ps
module sector_guard_link
    import sector_guard_pkg::*;
(
    input wire logic sck,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic si,
    input wire logic [63:0] protect_q,
    input wire logic [63:0] lock_q,
    output logic so,
    output logic rd_active,
    frame_event_if.link ev
);
    // ------------------------------------------------------------
    // shift-in on rising sck; opcode bytes, then payload
    // ------------------------------------------------------------
    logic [6:0] bit_sh;
    logic [2:0] bit_cnt;
    logic [7:0] byte_cnt;
    logic [7:0] op0;
    logic [7:0] op3;
    logic prefix_ok;
    logic [63:0] data;
    logic [23:0] addr;
    logic [7:0] rx_byte;
    logic [6:0] tx_idx;
    logic [7:0] pcount;
    job_t pend_job;

    assign rx_byte = {bit_sh, si};

    // cs_n high resets the frame state; sck stops outside frames
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bit_sh <= 7'h00;
            bit_cnt <= 3'h0;
            byte_cnt <= 8'h00;
            op0 <= 8'h00;
            op3 <= 8'h00;
            prefix_ok <= 1'b0;
            addr <= 24'h000000;
            pcount <= 8'h00;
        end else begin
            bit_sh <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                if (byte_cnt != 8'hff)
                    byte_cnt <= byte_cnt + 8'h01;
                unique case (byte_cnt)
                    8'h00: begin
                        op0 <= rx_byte;
                        prefix_ok <= (rx_byte == op_prefix0);
                    end
                    8'h01: prefix_ok <= prefix_ok && rx_byte == op_prefix1;
                    8'h02: prefix_ok <= prefix_ok && rx_byte == op_prefix2;
                    8'h03: op3 <= rx_byte;
                    default: begin
                        if (prefix_ok && op3 == op_protect_program
                            && pcount != 8'hff)
                            pcount <= pcount + 8'h01;
                        if (byte_cnt < 8'h07)
                            addr <= {addr[15:0], rx_byte};
                    end
                endcase
            end
        end
    end

    // data bytes wrap modulo eight; sector 0 lands in the top byte
    always_ff @(posedge sck) begin
        if (!cs_n && bit_cnt == 3'h7 && byte_cnt >= 8'h04 && prefix_ok
            && op3 == op_protect_program)
            data[8*(7 - pcount[2:0]) +: 8] <= rx_byte;
    end

    // ------------------------------------------------------------
    // shift-out on falling sck after opcode and dummies
    // ------------------------------------------------------------
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so <= 1'b0;
            rd_active <= 1'b0;
            tx_idx <= 7'h00;
        end else if (byte_cnt >= 8'(1 + dummy_bytes)
            && (op0 == op_protect_read || op0 == op_lock_read)) begin
            rd_active <= 1'b1;
            // past the eighth byte the pointer wraps: data is undefined
            so <= (op0 == op_protect_read) ? protect_q[63 - tx_idx[5:0]]
                : lock_q[63 - tx_idx[5:0]];
            tx_idx <= tx_idx + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // frame end: cs_n rising publishes the command
    // ------------------------------------------------------------
    always_comb begin
        pend_job = job_none;
        if (prefix_ok && bit_cnt == 3'h0) begin
            if (op3 == op_protect_program && byte_cnt >= 8'h05)
                pend_job = job_program;
            else if (op3 == op_lockdown && byte_cnt == 8'h07)
                pend_job = job_lockdown;
        end
    end

    // the core edge detector needs a known toggle level to start from
    always_ff @(posedge cs_n or negedge reset_n) begin
        if (!reset_n)
            ev.toggle <= 1'b0;
        else if (pend_job != job_none)
            ev.toggle <= ~ev.toggle;
    end

    // unknown opcode sequences publish nothing
    always_ff @(posedge cs_n) begin
        if (pend_job != job_none) begin
            ev.job <= pend_job;
            ev.data <= data;
            ev.count <= pcount;
            ev.addr <= addr;
        end
    end
endmodule : sector_guard_link

// file: src/sector_guard_pkg.sv
package sector_guard_pkg;
    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] op_prefix0 = 8'h3d;
    localparam logic [7:0] op_prefix1 = 8'h2a;
    localparam logic [7:0] op_prefix2 = 8'h7f;
    localparam logic [7:0] op_protect_program = 8'hfc;
    localparam logic [7:0] op_lockdown = 8'h30;
    localparam logic [7:0] op_protect_read = 8'h32;
    localparam logic [7:0] op_lock_read = 8'h35;
    // ------------------------------------------------------------
    // layout
    // ------------------------------------------------------------
    localparam int sector_count = 8;
    localparam int dummy_bytes = 3;
    localparam int addr_bytes = 3;
    localparam int addr_width = 24;
    localparam int sector_lsb = 16;
    localparam int part0a_page_limit = 8;
    localparam int page_lsb = 8;
    localparam logic [7:0] byte_set = 8'hff;
    localparam logic [7:0] byte_clear = 8'h00;
    localparam logic [7:0] part0a_mask = 8'hc0;
    localparam logic [7:0] part0b_mask = 8'h30;
    localparam logic [63:0] protect_reset = 64'h0000_0000_0000_0000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int clk_period_ns = 100;
    localparam int self_timed_program_time_us = 5000;
    localparam int self_timed_program_cycles =
        (self_timed_program_time_us * 1000) / clk_period_ns;

    typedef enum logic [1:0] {
        job_none,
        job_program,
        job_lockdown
    } job_t;
endpackage : sector_guard_pkg

// file: testbench/flash_sector_protect_lockdown_cmds_tb.sv
`timescale 1ns/10ps
module flash_sector_protect_lockdown_cmds_tb;
    import sector_guard_pkg::*;
    localparam logic [23:0] pfx = {op_prefix0, op_prefix1, op_prefix2};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic protect_enable = 1'b1;
    logic sck, cs_n, si, so, so_oe, busy;
    logic [7:0] sector_locked, sector_write_allowed;
    logic [63:0] rx;
    int fail_count = 0;
    int n_tests = 0;
    always #50 clk = ~clk;
    sector_guard #(.program_cycles(20)) dut (.clk, .reset_n, .sck, .cs_n,
        .si, .protect_enable, .so, .so_oe, .busy, .sector_locked,
        .sector_write_allowed);
    spi_host host (.sck, .cs_n, .si, .so);
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic cmd(input int n, input logic [127:0] tx, input logic b);
        host.frame(n, tx, 1'b0, rx);
        check(busy, b);
        for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clk);
        // status outputs are registered one clock after the commit
        repeat (2) @(negedge clk);
        check(busy, 1'b0);
    endtask : cmd
    task automatic rd(input logic [7:0] op, input logic [63:0] exp);
        host.frame(12, {op, 120'h0}, 1'b1, rx);
        check(rx, exp);
        check(so_oe, 1'b0);
    endtask : rd
    task automatic set_enable(input logic e);
        @(negedge clk);
        protect_enable = e;
        repeat (3) @(negedge clk);
    endtask : set_enable
    task automatic lock(input logic [23:0] addr, input logic [7:0] exp);
        cmd(7, {pfx, op_lockdown, addr, 72'h0}, 1'b1);
        check(sector_locked, exp);
    endtask : lock
    task automatic t_reset;
        check(busy, 1'b0);
        check(sector_locked, 8'h00);
        check(sector_write_allowed, 8'hff);
        rd(op_protect_read, 64'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_program;
        // ninth byte lands on location zero
        cmd(13, {pfx, op_protect_program, 64'h00ff00ffff0000ff, 8'hff,
            24'h0}, 1'b1);
        check(sector_write_allowed, 8'h64);
        rd(op_protect_read, 64'hffff00ffff0000ff);
        set_enable(1'b0);
        check(sector_write_allowed, 8'hff);
        cmd(6, {pfx, op_protect_program, 16'h0, 80'h0}, 1'b1);
        rd(op_protect_read, 64'h000000ffff0000ff);
        set_enable(1'b1);
        check(sector_write_allowed, 8'h67);
        $display("test program done");
    endtask : t_program
    task automatic t_lock;
        lock(24'h02abcd, 8'h04);
        check(sector_write_allowed, 8'h63);
        lock(24'h000510, 8'h05);
        lock(24'h008000, 8'h05);
        rd(op_lock_read, {8'hf0, 8'h00, 8'hff, 40'h0});
        // no erase command here; programs write straight over
        cmd(12, {pfx, op_protect_program, 64'h0, 32'h0}, 1'b1);
        check(sector_write_allowed, 8'hfa);
        set_enable(1'b0);
        check(sector_write_allowed, 8'hfa);
        $display("test lock done");
    endtask : t_lock
    task automatic t_refuse;
        cmd(4, {pfx, 8'h55, 96'h0}, 1'b0);
        cmd(6, {pfx, op_lockdown, 16'h0700, 80'h0}, 1'b0);
        check(sector_locked, 8'h05);
        rd(op_lock_read, {8'hf0, 8'h00, 8'hff, 40'h0});
        $display("test refuse done");
    endtask : t_refuse
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_program();
        t_lock();
        t_refuse();
        stop_test();
    end
endmodule : flash_sector_protect_lockdown_cmds_tb

// file: testbench/sector_guard_props.sv
`timescale 1ns/10ps
module sector_guard_props #(
    parameter int program_cycles = 20
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic protect_enable,
    input wire logic so,
    input wire logic so_oe,
    input wire logic busy,
    input wire logic [7:0] sector_locked,
    input wire logic [7:0] sector_write_allowed
);
    logic [31:0] busy_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // counts sampled busy cycles so the long cycle needs no repetition
    always_ff @(posedge clk) begin
        if (!reset_n || !busy) busy_cnt <= 32'h0;
        else busy_cnt <= busy_cnt + 32'h1;
    end
    property p_reset_vals;
        disable iff (1'b0) !reset_n |=> !busy && sector_locked == 8'h00
            && sector_write_allowed == 8'hff;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values");
    property p_busy_len;
        $fell(busy) |-> busy_cnt == program_cycles;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    property p_busy_after_cs;
        $rose(busy) |-> cs_n && $past(cs_n, 2);
    endproperty
    a_busy_after_cs: assert property (p_busy_after_cs) else $error("busy");
    property p_busy_gap;
        $fell(busy) |-> (!busy) [*4];
    endproperty
    a_busy_gap: assert property (p_busy_gap) else $error("busy again");
    property p_lock_sticky;
        (~sector_locked & $past(sector_locked)) == 8'h00;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("unlock");
    property p_lock_grow;
        $changed(sector_locked) |->
            $onehot(sector_locked ^ $past(sector_locked));
    endproperty
    a_lock_grow: assert property (p_lock_grow) else $error("lock grow");
    property p_locked_denies;
        ($past(sector_locked) & sector_write_allowed) == 8'h00;
    endproperty
    a_locked_denies: assert property (p_locked_denies) else $error("deny");
    property p_unprot_allowed;
        (!protect_enable) [*3] ##0 $stable(sector_locked) |->
            sector_write_allowed == ~sector_locked;
    endproperty
    a_unprot_allowed: assert property (p_unprot_allowed) else $error("off");
    property p_so_hiz;
        $rose(cs_n) |-> ##[0:4] !so_oe;
    endproperty
    a_so_hiz: assert property (p_so_hiz) else $error("so still on");
endmodule : sector_guard_props
bind sector_guard sector_guard_props #(.program_cycles(program_cycles)) props (
    .clk, .reset_n, .sck, .cs_n, .si, .protect_enable, .so, .so_oe, .busy,
    .sector_locked, .sector_write_allowed);

// file: testbench/spi_host.sv
`timescale 1ns/10ps
module spi_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    initial begin
        sck = 1'b0;
        si = 1'b0;
        // a chip select rise before any frame clears the link state
        cs_n = 1'b0;
        #10;
        cs_n = 1'b1;
    end
    // mode 0: the clock rests low and runs only inside a frame
    task automatic frame(input int n, input logic [127:0] tx,
        input bit slow, output logic [63:0] rx);
        cs_n = 1'b0;
        #20;
        for (int i = 0; i < n * 8; i++) begin
            si = tx[127 - i];
            // so is retimed on the core clock, so reads need a long low phase
            if (slow) #400;
            else #7.5;
            rx = {rx[62:0], so};
            sck = 1'b1;
            #7.5;
            sck = 1'b0;
        end
        #20;
        cs_n = 1'b1;
        si = ~si;
        #500;
    endtask : frame
endmodule : spi_host
